// >>> src/dss_pkg.sv
package dss_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_OPERATING   = 8'h00;
    localparam logic [7:0] ADDR_PRIO_LOW    = 8'h04;
    localparam logic [7:0] ADDR_CONTROL     = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLEAR   = 8'h14;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int         PRI_ALARM_BIT    = 5;
    localparam int         SEC_ALARM_BIT    = 4;
    localparam int         SEC_LOCK_BIT     = 6;
    localparam int         VIEW_SELECT_BIT  = 4;
    localparam logic [7:0] OPERATING_RESET  = 8'h41;
    localparam logic [7:0] PRIO_LOW_RESET   = 8'h00;
    localparam logic [2:0] IRQ_WIDTH_RESET  = 3'h0;

    // ****************************************
    // primary path state codes
    // ****************************************
    localparam logic [2:0] ST_FREE_RUN      = 3'h1;
    localparam logic [2:0] ST_HOLDOVER      = 3'h2;
    localparam logic [2:0] ST_LOCKED        = 3'h4;
    localparam logic [2:0] ST_PRE_LOCKED2   = 3'h5;
    localparam logic [2:0] ST_PRE_LOCKED    = 3'h6;
    localparam logic [2:0] ST_PHASE_LOST    = 3'h7;

    // ****************************************
    // source channel codes
    // ****************************************
    localparam logic [3:0] SRC_NONE         = 4'h0;
    localparam logic [3:0] SRC_IN1          = 4'h3;
    localparam logic [3:0] SRC_IN2          = 4'h4;
    localparam logic [3:0] SRC_IN3          = 4'h8;
    localparam logic [3:0] SRC_IN4          = 4'h9;

    // AXI responses
    localparam logic [1:0] RESP_OKAY        = 2'h0;
    localparam logic [1:0] RESP_SLVERR      = 2'h2;

    // per-path status carried from the tracking logic
    typedef struct packed {
        logic       soft_alarm;
        logic [3:0] best_src;
        logic [3:0] sel_src;
    } dss_path_s;

    typedef enum logic [2:0] {
        RD_IDLE = 3'b001,
        RD_DATA = 3'b010,
        RD_HOLD = 3'b100
    } dss_rd_e;

endpackage

// >>> src/dss_status.sv
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - each path has its own programmable frequency limit and separate soft alarm limit, both held in the tracking logic.
// - bit 4 of the operating register reads 1 while the secondary path tracks beyond its soft limit, else 0.
// - bit 5 of the operating register reads 1 while the primary path tracks beyond its soft limit, else 0.
// - bits 2:0 carry the primary state: 001 free run, 010 holdover, 100 locked, 101, 110, 111; 000 and 011 unused.
// - bits 7:4 of the priority byte give the highest-priority validated source of the viewed path.
// - both source fields use 0000 none and 0011, 0100, 1000, 1001 for inputs one to four.
// - the path-view select bit shows the primary path when 0 and the secondary path when 1.
// - the secondary path has no non-revertive mode, so its two source fields always match.
// - the priority byte is read-only and reads zero after reset.
// - the operating register is read-only and resets to 0100 0001.
module dss_status
    import dss_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        pri_soft_alarm,
    input  wire logic [2:0]  pri_state,
    input  wire logic [3:0]  pri_best_src,
    input  wire logic [3:0]  pri_sel_src,
    input  wire logic        sec_soft_alarm,
    input  wire logic        sec_locked,
    input  wire logic [3:0]  sec_best_src,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irq
);

    // ****************************************
    // status snapshot
    // ****************************************
    // limits themselves live in the tracking logic; only the alarm outcome arrives here
    dss_path_s   pri_q;
    dss_path_s   sec_q;
    logic [2:0]  state_q;
    logic        lock_q;
    logic        view_q;
    logic [7:0]  oper_q;
    logic [7:0]  prio_q;

    // all inputs come from logic on aclk, so one register stage gives the snapshot
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pri_q <= '0;
        end else begin
            pri_q <= '{pri_soft_alarm, pri_best_src, pri_sel_src};
        end
    end

    // no non-revertive mode on the secondary path, so selected mirrors best
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sec_q <= '0;
        end else begin
            sec_q <= '{sec_soft_alarm, sec_best_src, sec_best_src};
        end
    end

    // reset values follow the operating register so the first snapshot agrees with it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= OPERATING_RESET[2:0];
        end else begin
            state_q <= pri_state;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_q <= OPERATING_RESET[SEC_LOCK_BIT];
        end else begin
            lock_q <= sec_locked;
        end
    end

    function automatic logic [3:0] src_code(input logic [3:0] c);
        // unused codes fold to none so software never sees a reserved value
        case (c)
            SRC_IN1, SRC_IN2, SRC_IN3, SRC_IN4: src_code = c;
            default:                            src_code = SRC_NONE;
        endcase
    endfunction

    function automatic logic [2:0] state_code(input logic [2:0] s);
        case (s)
            ST_FREE_RUN, ST_HOLDOVER, ST_LOCKED, ST_PRE_LOCKED2, ST_PRE_LOCKED, ST_PHASE_LOST: state_code = s;
            default: state_code = ST_FREE_RUN;
        endcase
    endfunction

    logic [7:0] oper_d;
    logic [7:0] prio_d;
    dss_path_s  view_path;

    always_comb begin
        oper_d                = 8'h00;
        oper_d[SEC_LOCK_BIT]  = lock_q;
        oper_d[PRI_ALARM_BIT] = pri_q.soft_alarm;
        oper_d[SEC_ALARM_BIT] = sec_q.soft_alarm;
        oper_d[2:0]           = state_code(state_q);
        view_path             = view_q ? sec_q : pri_q;
        prio_d                = {src_code(view_path.best_src), src_code(view_path.sel_src)};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oper_q <= OPERATING_RESET;
        end else begin
            oper_q <= oper_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prio_q <= PRIO_LOW_RESET;
        end else begin
            prio_q <= prio_d;
        end
    end

    // ****************************************
    // interrupts
    // ****************************************
    // events: primary alarm rise, secondary alarm rise, primary state change
    logic [2:0] ev;
    logic [2:0] ist_q;
    logic [2:0] ien_q;
    logic [2:0] iclr;
    logic [7:0] oper_prev_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oper_prev_q <= OPERATING_RESET;
        end else begin
            oper_prev_q <= oper_q;
        end
    end

    assign ev = {oper_q[2:0] != oper_prev_q[2:0],
                 oper_q[SEC_ALARM_BIT] & ~oper_prev_q[SEC_ALARM_BIT],
                 oper_q[PRI_ALARM_BIT] & ~oper_prev_q[PRI_ALARM_BIT]};

    // set wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ist_q <= IRQ_WIDTH_RESET;
        end else begin
            ist_q <= (ist_q & ~iclr) | ev;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((ist_q & ~iclr) | ev) & ien_q);
        end
    end

    // ****************************************
    // axi4-lite write
    // ****************************************
    logic        aw_have_q;
    logic        w_have_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_go;

    assign wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            aw_have_q     <= 1'b0;
            aw_addr_q     <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_have_q     <= 1'b1;
            aw_addr_q     <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_have_q     <= 1'b0;
        end else if (!aw_have_q && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b1;
            w_have_q     <= 1'b0;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_have_q     <= 1'b1;
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
        end else if (wr_go) begin
            w_have_q     <= 1'b0;
        end else if (!w_have_q && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    function automatic logic addr_known(input logic [7:0] a);
        case (a)
            ADDR_OPERATING, ADDR_PRIO_LOW, ADDR_CONTROL,
            ADDR_IRQ_STATUS, ADDR_IRQ_ENABLE, ADDR_IRQ_CLEAR: addr_known = 1'b1;
            default: addr_known = 1'b0;
        endcase
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_known(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // status registers are read-only: writes to them are accepted and dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            view_q <= 1'b0;
        end else if (wr_go && w_strb_q[0] && aw_addr_q == ADDR_CONTROL) begin
            view_q <= w_data_q[VIEW_SELECT_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ien_q <= IRQ_WIDTH_RESET;
        end else if (wr_go && w_strb_q[0] && aw_addr_q == ADDR_IRQ_ENABLE) begin
            ien_q <= w_data_q[2:0];
        end
    end

    assign iclr = (wr_go && w_strb_q[0] && aw_addr_q == ADDR_IRQ_CLEAR) ? w_data_q[2:0] : 3'h0;

    // ****************************************
    // axi4-lite read
    // ****************************************
    dss_rd_e    rd_q;
    logic [7:0] rd_addr_q;
    logic [7:0] rd_val;

    always_comb begin
        case (rd_addr_q)
            ADDR_OPERATING:  rd_val = oper_q;
            ADDR_PRIO_LOW:   rd_val = prio_q;
            ADDR_CONTROL:    rd_val = {3'h0, view_q, 4'h0};
            ADDR_IRQ_STATUS: rd_val = {5'h00, ist_q};
            ADDR_IRQ_ENABLE: rd_val = {5'h00, ien_q};
            default:         rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_q          <= RD_IDLE;
            rd_addr_q     <= 8'h00;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            case (rd_q)
                RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        rd_addr_q     <= s_axi_araddr;
                        s_axi_arready <= 1'b0;
                        rd_q          <= RD_DATA;
                    end
                end
                RD_DATA: begin
                    // whole byte taken in one cycle, so fields never tear
                    s_axi_rdata  <= {24'h000000, rd_val};
                    s_axi_rresp  <= addr_known(rd_addr_q) ? RESP_OKAY : RESP_SLVERR;
                    s_axi_rvalid <= 1'b1;
                    rd_q         <= RD_HOLD;
                end
                RD_HOLD: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid  <= 1'b0;
                        s_axi_arready <= 1'b1;
                        rd_q          <= RD_IDLE;
                    end
                end
                default: begin
                    rd_q <= RD_IDLE;
                end
            endcase
        end
    end

endmodule

// >>> test/dss_status_asserts.sv
`timescale 1ns/1ps
// ********
// bus and snapshot checks
// ********
module dss_status_asserts
    import dss_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        pri_soft_alarm,
    input wire logic [2:0]  pri_state,
    input wire logic [3:0]  pri_best_src,
    input wire logic [3:0]  pri_sel_src,
    input wire logic        sec_soft_alarm,
    input wire logic        sec_locked,
    input wire logic [3:0]  sec_best_src,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [7:0]  ra_q;
    logic [3:0]  st_q;
    logic [17:0] in_q;
    logic        rv_q;
    wire  [17:0] in_w = {pri_soft_alarm, pri_state, pri_best_src, pri_sel_src, sec_soft_alarm, sec_locked, sec_best_src};
    // only judge reads whose inputs held still long enough to reach the snapshot
    wire         rd_op = s_axi_rvalid && !rv_q && st_q > 4'h5 && ra_q == ADDR_OPERATING;
    always_ff @(posedge aclk) begin
        in_q <= in_w;
        rv_q <= s_axi_rvalid;
        if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
        if (!aresetn || in_w != in_q) st_q <= 4'h0;
        else if (st_q != 4'hF) st_q <= st_q + 4'h1;
    end
    function automatic logic ok(input logic [3:0] c);
        return c inside {SRC_NONE, SRC_IN1, SRC_IN2, SRC_IN3, SRC_IN4};
    endfunction
    property p_rst;
        disable iff (1'h0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq;
    endproperty
    property p_rd_lat;
        s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid;
    endproperty
    property p_wr_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_sec_alarm;
        rd_op |-> s_axi_rdata[SEC_ALARM_BIT] == sec_soft_alarm;
    endproperty
    property p_pri_alarm;
        rd_op |-> s_axi_rdata[PRI_ALARM_BIT] == pri_soft_alarm;
    endproperty
    property p_state;
        rd_op |-> s_axi_rdata[3:0] == {1'h0, (pri_state == 3'h0 || pri_state == 3'h3) ? ST_FREE_RUN : pri_state};
    endproperty
    property p_src;
        s_axi_rvalid && ra_q == ADDR_PRIO_LOW && s_axi_rresp == RESP_OKAY |-> ok(s_axi_rdata[7:4]) && ok(s_axi_rdata[3:0]);
    endproperty
    a_rst: assert property (p_rst) else $error("bus busy after reset");
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
    a_r_hold: assert property (p_r_hold) else $error("read data moved");
    a_sec_alarm: assert property (p_sec_alarm) else $error("secondary alarm bit wrong");
    a_pri_alarm: assert property (p_pri_alarm) else $error("primary alarm bit wrong");
    a_state: assert property (p_state) else $error("state field wrong");
    a_src: assert property (p_src) else $error("source code illegal");
    c_rd_op: cover property (rd_op);
    c_irq: cover property ($rose(irq));
    c_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
bind dss_status dss_status_asserts i_chk (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .pri_soft_alarm (pri_soft_alarm),
    .pri_state      (pri_state),
    .pri_best_src   (pri_best_src),
    .pri_sel_src    (pri_sel_src),
    .sec_soft_alarm (sec_soft_alarm),
    .sec_locked     (sec_locked),
    .sec_best_src   (sec_best_src),
    .s_axi_awvalid  (s_axi_awvalid),
    .s_axi_awready  (s_axi_awready),
    .s_axi_wvalid   (s_axi_wvalid),
    .s_axi_wready   (s_axi_wready),
    .s_axi_bvalid   (s_axi_bvalid),
    .s_axi_araddr   (s_axi_araddr),
    .s_axi_arvalid  (s_axi_arvalid),
    .s_axi_arready  (s_axi_arready),
    .s_axi_rdata    (s_axi_rdata),
    .s_axi_rresp    (s_axi_rresp),
    .s_axi_rvalid   (s_axi_rvalid),
    .s_axi_rready   (s_axi_rready),
    .irq            (irq)
);

// >>> test/test_dss_status.sv
`timescale 1ns/1ps
// ********
// bench for the status bank
// ********
module test_dss_status
    import dss_pkg::*;
;
    logic        aclk, aresetn, pri_soft_alarm, sec_soft_alarm, sec_locked, irq, view;
    logic [2:0]  pri_state;
    logic [3:0]  pri_best_src, pri_sel_src, sec_best_src, s_axi_wstrb;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs_q;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int          err_count, n_checks;
    dss_status i_dut (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .pri_soft_alarm (pri_soft_alarm),
        .pri_state      (pri_state),
        .pri_best_src   (pri_best_src),
        .pri_sel_src    (pri_sel_src),
        .sec_soft_alarm (sec_soft_alarm),
        .sec_locked     (sec_locked),
        .sec_best_src   (sec_best_src),
        .s_axi_awaddr   (s_axi_awaddr),
        .s_axi_awvalid  (s_axi_awvalid),
        .s_axi_awready  (s_axi_awready),
        .s_axi_wdata    (s_axi_wdata),
        .s_axi_wstrb    (s_axi_wstrb),
        .s_axi_wvalid   (s_axi_wvalid),
        .s_axi_wready   (s_axi_wready),
        .s_axi_bresp    (s_axi_bresp),
        .s_axi_bvalid   (s_axi_bvalid),
        .s_axi_bready   (s_axi_bready),
        .s_axi_araddr   (s_axi_araddr),
        .s_axi_arvalid  (s_axi_arvalid),
        .s_axi_arready  (s_axi_arready),
        .s_axi_rdata    (s_axi_rdata),
        .s_axi_rresp    (s_axi_rresp),
        .s_axi_rvalid   (s_axi_rvalid),
        .s_axi_rready   (s_axi_rready),
        .irq            (irq)
    );
    task automatic chk_d(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t data %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_r(input logic [1:0] got, input logic [1:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t resp %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        rs_q = s_axi_bresp;
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        rd_q = s_axi_rdata;
        rs_q = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask
    function automatic logic [3:0] src(input logic [3:0] c);
        return (c inside {SRC_IN1, SRC_IN2, SRC_IN3, SRC_IN4}) ? c : SRC_NONE;
    endfunction
    function automatic logic [31:0] exp_op();
        logic [2:0] s;
        s = (pri_state == 3'h0 || pri_state == 3'h3) ? ST_FREE_RUN : pri_state;
        return {24'h0, 1'h0, sec_locked, pri_soft_alarm, sec_soft_alarm, 1'h0, s};
    endfunction
    function automatic logic [31:0] exp_pr();
        return view ? {24'h0, src(sec_best_src), src(sec_best_src)} : {24'h0, src(pri_best_src), src(pri_sel_src)};
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        aclk = 1'h0;
        forever #50 aclk = ~aclk;
    end
    // the tests need about 940 cycles; allow a wide margin
    initial begin
        #800000;
        err_count++;
        complete_run();
    end
    initial begin
        {aresetn, pri_soft_alarm, sec_soft_alarm, view, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {pri_best_src, pri_sel_src, sec_best_src} = '0;
        s_axi_wstrb = 4'hF;
        pri_state = ST_FREE_RUN;
        sec_locked = 1'h1;
        err_count = 0;
        n_checks = 0;
        void'($urandom(32'h9B81));
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(ADDR_OPERATING);
        chk_d(rd_q, {24'h0, OPERATING_RESET});
        wr(ADDR_PRIO_LOW, 32'hFF);
        chk_r(rs_q, RESP_OKAY);
        rd(ADDR_PRIO_LOW);
        chk_d(rd_q, {24'h0, PRIO_LOW_RESET});
        $display("test reset done");
        // first passes walk every state and source code, then random
        for (int i = 0; i < 40; i++) begin
            pri_state <= (i < 8) ? i[2:0] : 3'($urandom);
            pri_best_src <= (i < 16) ? i[3:0] : 4'($urandom);
            sec_best_src <= (i < 16) ? 4'(15 - i) : 4'($urandom);
            pri_sel_src <= 4'($urandom);
            {pri_soft_alarm, sec_soft_alarm, sec_locked, view} <= 4'($urandom);
            @(posedge aclk);
            wr(ADDR_CONTROL, 32'(view) << VIEW_SELECT_BIT);
            repeat (8) @(posedge aclk);
            rd(ADDR_OPERATING);
            chk_d(rd_q, exp_op());
            rd(ADDR_PRIO_LOW);
            chk_d(rd_q, exp_pr());
        end
        $display("test snapshot done");
        rd(8'h40);
        chk_r(rs_q, RESP_SLVERR);
        chk_d(rd_q, 32'h0);
        wr(8'h40, 32'h1);
        chk_r(rs_q, RESP_SLVERR);
        $display("test unmapped done");
        // a write without byte lane 0 must leave the view select alone
        wr(ADDR_CONTROL, 32'h0);
        s_axi_wstrb <= 4'hE;
        wr(ADDR_CONTROL, 32'h10);
        chk_r(rs_q, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(ADDR_CONTROL);
        chk_d(rd_q, 32'h0);
        wr(ADDR_CONTROL, 32'h10);
        rd(ADDR_CONTROL);
        chk_d(rd_q, 32'h10);
        $display("test strobe done");
        pri_soft_alarm <= 1'h0;
        repeat (4) @(posedge aclk);
        wr(ADDR_IRQ_CLEAR, 32'h7);
        wr(ADDR_IRQ_ENABLE, 32'h7);
        repeat (2) @(posedge aclk);
        chk_d({31'h0, irq}, 32'h0);
        pri_soft_alarm <= 1'h1;
        repeat (4) @(posedge aclk);
        chk_d({31'h0, irq}, 32'h1);
        rd(ADDR_IRQ_STATUS);
        chk_d(rd_q, 32'h1);
        wr(ADDR_IRQ_ENABLE, 32'h0);
        repeat (2) @(posedge aclk);
        chk_d({31'h0, irq}, 32'h0);
        wr(ADDR_IRQ_ENABLE, 32'h1);
        wr(ADDR_IRQ_CLEAR, 32'h1);
        repeat (2) @(posedge aclk);
        chk_d({31'h0, irq}, 32'h0);
        rd(ADDR_IRQ_STATUS);
        chk_d(rd_q, 32'h0);
        $display("test interrupt done");
        // second reset in mid-run: control and enable must fall back to zero
        aresetn <= 1'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        chk_d({31'h0, irq}, 32'h0);
        rd(ADDR_IRQ_ENABLE);
        chk_d(rd_q, 32'h0);
        rd(ADDR_CONTROL);
        chk_d(rd_q, 32'h0);
        $display("test second reset done");
        complete_run();
    end
endmodule
